// ### rtl/lss_pkg.sv
// Constants for the light sensor status and configuration registers
// Notes on behaviour
// - Event-pin direction bit: 0 input, 1 output; resets to output.
// - Source field: 0 alert, 1 every conversion, 2 invalid, 3 every four.
// - Reserved zero fields read as zero; host writes zero into them.
// - Burst bit set (reset 1): read pointer advances after each read.
// - Overflow indicator set when conversion overflows; read-only, resets 0.
// - Done indicator goes 1 at conversion end; 0 means busy; resets 0.
// - Done indicator clears on flag register read or non-zero write.
// - Above-limit indicator set after enough consecutive results over high limit.
// - Below-limit indicator set after enough consecutive results under low limit.
// - Hit setting 0,1,2,3 needs one, two, four, eight consecutive hits.
package lss_pkg;
  // Register pointer and offsets
  localparam int PTR_W = 5;
  localparam logic [4:0] OFS_INT_SETUP = 5'h0b;
  localparam logic [4:0] OFS_FLAG_STATUS = 5'h0c;
  localparam logic [4:0] OFS_PART_ID = 5'h11;

  // Interrupt setup fields
  localparam int SETUP_RSVD_LSB = 5;
  localparam int SETUP_DIR_BIT = 4;
  localparam int SETUP_SRC_LSB = 2;
  localparam int SETUP_BURST_BIT = 0;
  localparam logic [10:0] SETUP_RSVD_VAL = 11'h400;
  localparam logic [15:0] SETUP_RST = 16'h8011;
  localparam logic SETUP_DIR_RST = 1'b1;
  localparam logic [1:0] SETUP_SRC_RST = 2'h0;
  localparam logic SETUP_BURST_RST = 1'b1;

  // Event source encodings
  localparam logic [1:0] SRC_ALERT = 2'h0;
  localparam logic [1:0] SRC_EVERY = 2'h1;
  localparam logic [1:0] SRC_INVALID = 2'h2;
  localparam logic [1:0] SRC_FOURTH = 2'h3;
  localparam logic [1:0] FOURTH_LAST = 2'h3;

  // Flag status fields
  localparam int FLG_OVF_BIT = 3;
  localparam int FLG_DONE_BIT = 2;
  localparam int FLG_HIGH_BIT = 1;
  localparam int FLG_LOW_BIT = 0;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Part identifier fields
  localparam int ID_LOW_LSB = 12;
  localparam int ID_HIGH_LSB = 0;

  // Event pulse timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int EVT_PULSE_NS = 1000;
  localparam int EVT_PULSE_CYC =
    (EVT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EVT_CNT_W = 8;
endpackage : lss_pkg

// ### rtl/lss_sync.sv
// Two-stage synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module lss_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : lss_sync
`default_nettype wire

// ### rtl/lss_hit_count.sv
// Consecutive limit-violation counter
`timescale 1ns/1ps
`default_nettype none
module lss_hit_count (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sample_in,
  input wire logic hit_in,
  input wire logic [1:0] sel_in,
  output logic trip_out
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] need;
  logic trip_reg;
  logic trip_next;

  always_comb begin
    need = 4'h1 << sel_in;
    cnt_next = cnt_reg;
    trip_next = 1'b0;
    if (sample_in) begin
      if (hit_in) begin
        if (cnt_reg < need) begin
          cnt_next = cnt_reg + 4'h1;
        end
        trip_next = (cnt_reg + 4'h1) >= need;
      end else begin
        cnt_next = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 4'h0;
      trip_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      trip_reg <= trip_next;
    end
  end

  assign trip_out = trip_reg;
endmodule : lss_hit_count
`default_nettype wire

// ### rtl/lss_regs.sv
// Status, event setup and identification registers of the light sensor
`timescale 1ns/1ps
`default_nettype none
module lss_regs #(
  parameter logic [1:0] PART_ID_LOW = 2'h0, // Arbitrary value
  parameter logic [11:0] PART_ID_HIGH = 12'h0a5 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ptr_load_in,
  input wire logic [4:0] ptr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic conv_done_in,
  input wire logic overflow_in,
  input wire logic above_high_in,
  input wire logic below_low_in,
  input wire logic [1:0] hit_sel_in,
  input wire logic event_pol_in,
  input wire logic event_pin_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [4:0] read_ptr_out,
  output logic burst_en_out,
  output logic event_pin_out,
  output logic event_pin_oe_out,
  output logic trigger_out
);
  typedef enum logic [0:0] {
    EV_IDLE,
    EV_PULSE
  } lss_ev_state_t;

  // Register pointer and read data
  logic [4:0] ptr_reg;
  logic [4:0] ptr_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // Interrupt setup fields
  logic dir_reg;
  logic dir_next;
  logic [1:0] src_reg;
  logic [1:0] src_next;
  logic burst_reg;
  logic burst_next;

  // Flags
  logic ovf_reg;
  logic ovf_next;
  logic done_reg;
  logic done_next;
  logic high_reg;
  logic high_next;
  logic low_reg;
  logic low_next;

  // Event pin
  lss_ev_state_t ev_state_reg;
  lss_ev_state_t ev_state_next;
  logic [7:0] ev_cnt_reg;
  logic [7:0] ev_cnt_next;
  logic [1:0] conv_cnt_reg;
  logic [1:0] conv_cnt_next;
  logic pin_reg;
  logic pin_next;
  logic oe_reg;
  logic oe_next;
  logic pin_prev_reg;
  logic pin_prev_next;
  logic trig_reg;
  logic trig_next;

  logic pin_sync;
  logic high_trip;
  logic low_trip;
  logic flag_rd;
  logic flag_clr_wr;
  logic start_pulse;

  function automatic logic [15:0] read_word(
    input logic [4:0] addr,
    input logic dir,
    input logic [1:0] src,
    input logic burst,
    input logic [3:0] flags
  );
    logic [15:0] w;
    w = 16'h0000;
    case (addr)
      lss_pkg::OFS_INT_SETUP: begin
        w[15:lss_pkg::SETUP_RSVD_LSB] = lss_pkg::SETUP_RSVD_VAL;
        w[lss_pkg::SETUP_DIR_BIT] = dir;
        w[lss_pkg::SETUP_SRC_LSB +: 2] = src;
        w[lss_pkg::SETUP_BURST_BIT] = burst;
      end
      lss_pkg::OFS_FLAG_STATUS: begin
        w[3:0] = flags;
      end
      lss_pkg::OFS_PART_ID: begin
        w[lss_pkg::ID_LOW_LSB +: 2] = PART_ID_LOW;
        w[lss_pkg::ID_HIGH_LSB +: 12] = PART_ID_HIGH;
      end
      default: begin
        w = 16'h0000;
      end
    endcase
    return w;
  endfunction : read_word

  lss_sync u_pin_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(event_pin_in),
    .sync_out(pin_sync)
  );

  lss_hit_count u_high_hits (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .sample_in(conv_done_in),
    .hit_in(above_high_in),
    .sel_in(hit_sel_in),
    .trip_out(high_trip)
  );

  lss_hit_count u_low_hits (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .sample_in(conv_done_in),
    .hit_in(below_low_in),
    .sel_in(hit_sel_in),
    .trip_out(low_trip)
  );

  assign flag_rd = reg_rd_in && (ptr_reg == lss_pkg::OFS_FLAG_STATUS);
  assign flag_clr_wr = reg_wr_in && (ptr_reg == lss_pkg::OFS_FLAG_STATUS)
    && (reg_wdata_in != 16'h0000);

  // Pointer, read data and setup register
  always_comb begin
    ptr_next = ptr_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    dir_next = dir_reg;
    src_next = src_reg;
    burst_next = burst_reg;
    if (ptr_load_in) begin
      ptr_next = ptr_in;
    end else if (reg_rd_in) begin
      rdata_next = read_word(ptr_reg, dir_reg, src_reg, burst_reg,
        {ovf_reg, done_reg, high_reg, low_reg});
      rvalid_next = 1'b1;
      if (burst_reg) begin
        ptr_next = ptr_reg + 5'h01;
      end
    end
    if (reg_wr_in && !ptr_load_in &&
        (ptr_reg == lss_pkg::OFS_INT_SETUP)) begin
      dir_next = reg_wdata_in[lss_pkg::SETUP_DIR_BIT];
      src_next = reg_wdata_in[lss_pkg::SETUP_SRC_LSB +: 2];
      burst_next = reg_wdata_in[lss_pkg::SETUP_BURST_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ptr_reg <= 5'h00;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      dir_reg <= lss_pkg::SETUP_DIR_RST;
      src_reg <= lss_pkg::SETUP_SRC_RST;
      burst_reg <= lss_pkg::SETUP_BURST_RST;
    end else begin
      ptr_reg <= ptr_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      dir_reg <= dir_next;
      src_reg <= src_next;
      burst_reg <= burst_next;
    end
  end

  // Flags; a new event wins over a clear in the same cycle
  always_comb begin
    ovf_next = ovf_reg;
    done_next = done_reg;
    high_next = high_reg;
    low_next = low_reg;
    if (flag_rd || flag_clr_wr) begin
      done_next = 1'b0;
      high_next = 1'b0;
      low_next = 1'b0;
    end
    if (conv_done_in) begin
      done_next = 1'b1;
      ovf_next = overflow_in;
    end
    if (high_trip) begin
      high_next = 1'b1;
    end
    if (low_trip) begin
      low_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ovf_reg <= lss_pkg::FLAGS_RST[lss_pkg::FLG_OVF_BIT];
      done_reg <= lss_pkg::FLAGS_RST[lss_pkg::FLG_DONE_BIT];
      high_reg <= lss_pkg::FLAGS_RST[lss_pkg::FLG_HIGH_BIT];
      low_reg <= lss_pkg::FLAGS_RST[lss_pkg::FLG_LOW_BIT];
    end else begin
      ovf_reg <= ovf_next;
      done_reg <= done_next;
      high_reg <= high_next;
      low_reg <= low_next;
    end
  end

  // Event pin driver and trigger input
  always_comb begin
    ev_state_next = ev_state_reg;
    ev_cnt_next = ev_cnt_reg;
    conv_cnt_next = conv_cnt_reg;
    start_pulse = 1'b0;
    if (conv_done_in) begin
      conv_cnt_next = conv_cnt_reg + 2'h1;
      case (src_reg)
        lss_pkg::SRC_EVERY: begin
          start_pulse = 1'b1;
        end
        lss_pkg::SRC_FOURTH: begin
          start_pulse = (conv_cnt_reg == lss_pkg::FOURTH_LAST);
        end
        default: begin
          start_pulse = 1'b0;
        end
      endcase
    end
    case (ev_state_reg)
      EV_IDLE: begin
        if (start_pulse) begin
          ev_state_next = EV_PULSE;
          ev_cnt_next = 8'(lss_pkg::EVT_PULSE_CYC - 1);
        end
      end
      EV_PULSE: begin
        if (ev_cnt_reg == 8'h00) begin
          ev_state_next = EV_IDLE;
        end else begin
          ev_cnt_next = ev_cnt_reg - 8'h01;
        end
      end
      default: begin
        ev_state_next = EV_IDLE;
      end
    endcase
    oe_next = dir_reg;
    if (!dir_reg) begin
      pin_next = ~event_pol_in;
    end else if (src_reg == lss_pkg::SRC_ALERT) begin
      pin_next = (high_reg || low_reg) ? event_pol_in : ~event_pol_in;
    end else if (src_reg == lss_pkg::SRC_INVALID) begin
      pin_next = ~event_pol_in;
    end else begin
      pin_next = (ev_state_next == EV_PULSE) ? event_pol_in
        : ~event_pol_in;
    end
    pin_prev_next = pin_sync;
    trig_next = !dir_reg && (pin_sync == event_pol_in)
      && (pin_prev_reg != event_pol_in);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ev_state_reg <= EV_IDLE;
      ev_cnt_reg <= 8'h00;
      conv_cnt_reg <= 2'h0;
      pin_reg <= 1'b1;
      oe_reg <= lss_pkg::SETUP_DIR_RST;
      pin_prev_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      ev_state_reg <= ev_state_next;
      ev_cnt_reg <= ev_cnt_next;
      conv_cnt_reg <= conv_cnt_next;
      pin_reg <= pin_next;
      oe_reg <= oe_next;
      pin_prev_reg <= pin_prev_next;
      trig_reg <= trig_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign read_ptr_out = ptr_reg;
  assign burst_en_out = burst_reg;
  assign event_pin_out = pin_reg;
  assign event_pin_oe_out = oe_reg;
  assign trigger_out = trig_reg;
endmodule : lss_regs
`default_nettype wire

// ### tb/lss_regs_asserts.sv
// Checker for the light sensor register block
`timescale 1ns/1ps
`default_nettype none
module lss_regs_asserts (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ptr_load_in,
  input wire logic [4:0] ptr_in,
  input wire logic reg_rd_in,
  input wire logic conv_done_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [4:0] read_ptr_out,
  input wire logic burst_en_out,
  input wire logic event_pin_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic rd_ok = reg_rd_in && !ptr_load_in;
  wire logic at_f = rd_ok && read_ptr_out == 5'h0c && !conv_done_in;
  AST_OE_RST: assert property ($rose(rst_b_in) |-> event_pin_oe_out)
    else $error("event pin not output after reset");
  AST_LOAD: assert property (ptr_load_in |=> read_ptr_out == $past(ptr_in))
    else $error("pointer load lost");
  AST_BURST: assert property (rd_ok && burst_en_out |=>
    read_ptr_out == $past(read_ptr_out) + 5'h01)
    else $error("pointer did not advance");
  AST_HOLD: assert property (rd_ok && !burst_en_out |=> $stable(read_ptr_out))
    else $error("pointer moved without burst");
  AST_SETUP_RSVD: assert property (rd_ok && read_ptr_out == 5'h0b |=>
    reg_rdata_out[15:5] == 11'h400 && !reg_rdata_out[1])
    else $error("setup reserved bits wrong");
  AST_FLAG_RSVD: assert property (at_f |=> reg_rdata_out[15:4] == 12'h000)
    else $error("flag reserved bits wrong");
  AST_ID_RSVD: assert property (rd_ok && read_ptr_out == 5'h11 |=>
    reg_rdata_out[15:14] == 2'h0)
    else $error("identifier reserved bits wrong");
  AST_DONE: assert property (conv_done_in ##1 (rd_ok && read_ptr_out == 5'h0c)
    |=> reg_rdata_out[2])
    else $error("done flag missing");
  AST_CLEAR: assert property (at_f ##1 at_f |=> !reg_rdata_out[2])
    else $error("done flag not cleared by read");
endmodule : lss_regs_asserts
bind lss_regs lss_regs_asserts u_chk (.clk_in, .rst_b_in, .ptr_load_in,
  .ptr_in, .reg_rd_in, .conv_done_in, .reg_rdata_out, .read_ptr_out,
  .burst_en_out, .event_pin_oe_out);
`default_nettype wire

// ### tb/lss_host.sv
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module lss_host (
  input wire logic clk_in,
  output logic ptr_load_out,
  output logic [4:0] ptr_out,
  output logic wr_out,
  output logic [15:0] wdata_out,
  output logic rd_out
);
  int seed = 49294;
  initial {ptr_load_out, ptr_out, wr_out, wdata_out, rd_out} = '0;
  // One port cycle; unused lines carry noise
  task automatic cyc(input logic ld, input logic [4:0] p, input logic wr,
    input logic [15:0] d, input logic rd);
    ptr_load_out = ld;
    ptr_out = ld ? p : 5'($random(seed));
    wr_out = wr;
    wdata_out = wr ? d : 16'($random(seed));
    rd_out = rd;
    @(negedge clk_in);
  endtask : cyc
endmodule : lss_host
`default_nettype wire

// ### tb/lss_regs_tb.sv
// Testbench for the light sensor register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module lss_regs_tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic conv_done_in = 1'b0;
  logic overflow_in = 1'b0;
  logic above_high_in = 1'b0;
  logic below_low_in = 1'b0;
  logic event_pol_in = 1'b1;
  logic ext_lvl = 1'b1;
  logic [1:0] hit_sel_in = 2'h0;
  logic ptr_load_in, reg_wr_in, reg_rd_in, reg_rvalid_out, burst_en_out;
  logic event_pin_out, event_pin_oe_out, trigger_out, act;
  logic [4:0] ptr_in, read_ptr_out;
  logic [15:0] reg_wdata_in, reg_rdata_out, e;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int check_count = 0;
  int conv_n = 0;
  int k;
  // Pin wire shared by device and outside driver; ext_lvl drives it while the device output is off
  wire logic event_pin_in = event_pin_oe_out ? event_pin_out : ext_lvl;
  always #2.5 clk_in = ~clk_in;
  lss_host u_host (.clk_in, .ptr_load_out(ptr_load_in), .ptr_out(ptr_in),
    .wr_out(reg_wr_in), .wdata_out(reg_wdata_in), .rd_out(reg_rd_in));
  lss_regs #(.PART_ID_LOW(2'h2), .PART_ID_HIGH(12'h3c7)) u_dut (.clk_in,
    .rst_b_in, .ptr_load_in, .ptr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
    .conv_done_in, .overflow_in, .above_high_in, .below_low_in, .hit_sel_in,
    .event_pol_in, .event_pin_in, .reg_rdata_out, .reg_rvalid_out,
    .read_ptr_out, .burst_en_out, .event_pin_out, .event_pin_oe_out,
    .trigger_out);
  task automatic idle(input int n);
    repeat (n) u_host.cyc(1'b0, 5'h00, 1'b0, 16'h0000, 1'b0);
  endtask : idle
  task automatic ld(input logic [4:0] p);
    u_host.cyc(1'b1, p, 1'b0, 16'h0000, 1'b0);
  endtask : ld
  task automatic wr(input logic [15:0] d);
    u_host.cyc(1'b0, 5'h00, 1'b1, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [15:0] x);
    exp_q.push_back(x);
    u_host.cyc(1'b0, 5'h00, 1'b0, 16'h0000, 1'b1);
  endtask : rd
  task automatic conv(input logic o, input logic h, input logic l);
    {conv_done_in, overflow_in, above_high_in, below_low_in} = {1'b1, o, h, l};
    idle(1);
    conv_done_in = 1'b0;
    {overflow_in, above_high_in, below_low_in} = ~{o, h, l};
    conv_n++;
  endtask : conv
  task automatic setup(input logic d, input logic [1:0] s);
    ld(5'h0b);
    wr({11'h400, d, s, 2'b00});
    rd({11'h400, d, s, 2'b00});
  endtask : setup
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(negedge clk_in) begin
    if (reg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("[FAIL] %0t unexpected read data", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK(reg_rdata_out, e)
      end
    end
  end
  initial begin
    event_pol_in = 1'($random(u_host.seed));
    ext_lvl = ~event_pol_in;
    repeat (5) @(negedge clk_in);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    `CHK(burst_en_out, 1'b1)
    ld(5'h0b);
    rd(16'h8011);
    rd(16'h0000);
    rd(16'h0000);
    `CHK(read_ptr_out, 5'h0e)
    ld(5'h11);
    rd(16'h23c7);
    for (k = 0; k < 4; k++) begin
      setup(1'b1, k[1:0]);
      conv(1'b0, 1'b0, 1'b0);
      act = (k == 1) || (k == 3 && conv_n % 4 == 0);
      `CHK(event_pin_out, act ? event_pol_in : ~event_pol_in)
      idle(199);
      `CHK(event_pin_out, act ? event_pol_in : ~event_pol_in)
      idle(1);
      `CHK(event_pin_out, ~event_pol_in)
    end
    setup(1'b1, 2'h0);
    ld(5'h0c);
    conv(1'b0, 1'b1, 1'b0);
    idle(2);
    `CHK(event_pin_out, event_pol_in)
    rd(16'h0006);
    rd(16'h0000);
    idle(2);
    `CHK(event_pin_out, ~event_pol_in)
    conv(1'b1, 1'b0, 1'b0);
    rd(16'h000c);
    conv(1'b0, 1'b0, 1'b0);
    rd(16'h0004);
    conv(1'b0, 1'b0, 1'b0);
    wr(16'h0001);
    rd(16'h0000);
    for (k = 0; k < 4; k++) begin
      hit_sel_in = k[1:0];
      conv(1'b0, 1'b0, 1'b0);
      rd(16'h0004);
      repeat ((1 << k) - 1) begin
        conv(1'b0, 1'b0, 1'b1);
        idle(1);
      end
      idle(2);
      rd((k > 0) ? 16'h0004 : 16'h0000);
      conv(1'b0, 1'b0, 1'b1);
      idle(2);
      rd(16'h0005);
    end
    setup(1'b0, 2'h1);
    `CHK(event_pin_oe_out, 1'b0)
    ext_lvl = event_pol_in;
    for (k = 0; k < 8 && trigger_out !== 1'b1; k++) idle(1);
    `CHK(trigger_out, 1'b1)
    rst_b_in = 1'b0;
    idle(5);
    rst_b_in = 1'b1;
    idle(1);
    `CHK(event_pin_oe_out, 1'b1)
    ld(5'h0b);
    rd(16'h8011);
    idle(2);
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule : lss_regs_tb
`default_nettype wire
